// ---- afest_params.svh ----
// Purpose: timing and field constants for the sample timing control
// Assumes: one system clock, pixel phases counted in master clock cycles
// Notes:   included by the package and the design modules
`ifndef AFEST_PARAMS_SVH
`define AFEST_PARAMS_SVH

`define AFEST_SCHEME_W        4
`define AFEST_CDS_BIT         0
`define AFEST_RATIO_W         4
`define AFEST_RATIO_3CH_8     4'h8
`define AFEST_RATIO_3CH_12    4'hC
`define AFEST_RATIO_2CH_6     4'h6
`define AFEST_RATIO_2CH_8     4'h8
`define AFEST_RATIO_1CH_CDS   4'h6
`define AFEST_RATIO_1CH_NCDS  4'h4
`define AFEST_FMAX_LOW_MHZ    8'h20
`define AFEST_FMAX_MID_MHZ    8'h28
`define AFEST_FMAX_HIGH_MHZ   8'h30
`define AFEST_SMPL_POS_W      4
`define AFEST_SOSEL_W         2
`define AFEST_SOSEL_SYNC      2'h1
`define AFEST_SOSEL_BOTH      2'h3
`define AFEST_DATA_W          12
`define AFEST_VIDEO_PHASE     4'h1
`define AFEST_RESET_SCHEME    4'h0
`define AFEST_RESET_POS       4'h2

`endif

// ---- afest_pkg.sv ----
// Purpose: shared types for the sample timing control
// Assumes: constants come from the params header
// Notes:   types only
`include "afest_params.svh"
package afest_pkg;
    typedef enum logic [1:0] {
        AFEST_CH_NONE,
        AFEST_CH_ONE,
        AFEST_CH_TWO,
        AFEST_CH_THREE
    } afest_chans_t;

    typedef enum {
        AFEST_IDLE,
        AFEST_RUN
    } afest_state_t;
endpackage : afest_pkg

// ---- afest_word_mux.sv ----
// Purpose: multiplex three channel words onto one converter output register
// Assumes: channel select stepped by the timing control
// Notes:   read data leave from a register
`timescale 1ns/1ns
`include "afest_params.svh"
module afest_word_mux
    import afest_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // channel words
    input  wire logic [`AFEST_DATA_W-1:0] ch0_word,
    input  wire logic [`AFEST_DATA_W-1:0] ch1_word,
    input  wire logic [`AFEST_DATA_W-1:0] ch2_word,
    input  wire logic [1:0]               ch_sel,
    input  wire logic                     load,
    // converted word
    output logic      [`AFEST_DATA_W-1:0] word_q
);
    // one converter shared among the channels in turn
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_q <= '0;
        end else if (load) begin
            case (ch_sel)
                2'h0:    word_q <= ch0_word;
                2'h1:    word_q <= ch1_word;
                default: word_q <= ch2_word;
            endcase
        end
    end
endmodule : afest_word_mux

// ---- afest_timing.sv ----
// Purpose: pixel sampling timing and mode control for a three-channel front end
// Assumes: clk is the master clock; control bits come as plain ports
// Notes:   sample strobes are one master clock wide, a long clamp pulse two; reserved codes run idle
`timescale 1ns/1ns
`include "afest_params.svh"
module afest_timing
    import afest_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // control bits written by the host over the management port
    input  wire logic [`AFEST_SCHEME_W-1:0] scheme_code,
    input  wire logic [`AFEST_SMPL_POS_W-1:0] reset_sample_position,
    input  wire logic                       short_clamp,
    input  wire logic                       self_sync_enable,
    input  wire logic                       sync_pin_output_enable,
    input  wire logic [`AFEST_SOSEL_W-1:0]  serial_out_select,
    // sensor side pins
    input  wire logic                       pixel_sync_in,
    input  wire logic                       clamp_request_pin,
    // channel words from the converter path
    input  wire logic [`AFEST_DATA_W-1:0]   ch0_word,
    input  wire logic [`AFEST_DATA_W-1:0]   ch1_word,
    input  wire logic [`AFEST_DATA_W-1:0]   ch2_word,
    input  wire logic [`AFEST_DATA_W-1:0]   data_bus_in,
    input  wire logic                       data_bus_read,
    // sync outputs
    output logic                            pixel_sync_out,
    output logic                            pixel_sync_oe,
    output logic                            serial_readback_pin,
    output logic                            serial_readback_oe,
    // internal strobes
    output logic                            clamp_pulse,
    output logic                            video_sample_strobe,
    output logic                            reference_sample_strobe,
    output logic                            ref_from_clamp_level,
    output logic                            cds_active,
    // status
    output logic [1:0]                      channel_count,
    output logic [7:0]                      max_mclk_mhz,
    output logic                            scheme_reserved,
    // data bus
    output logic [`AFEST_DATA_W-1:0]        data_bus_out,
    output logic                            data_bus_oe,
    output logic [`AFEST_DATA_W-1:0]        readback_q
);
    // decode the scheme into channels and clocks per pixel
    function automatic logic [`AFEST_RATIO_W+2:0] decode(
        input logic [3:0] c
    );
        logic [1:0] ch;
        logic [3:0] r;
        logic       v;
        ch = 2'h0;
        r  = 4'h0;
        v  = 1'b1;
        case (c)
            4'h0, 4'h1: begin ch = 2'h3; r = `AFEST_RATIO_3CH_8;   end
            4'h8, 4'h9: begin ch = 2'h3; r = `AFEST_RATIO_3CH_12;  end
            4'h4, 4'h5: begin ch = 2'h2; r = `AFEST_RATIO_2CH_6;   end
            4'hC, 4'hD: begin ch = 2'h2; r = `AFEST_RATIO_2CH_8;   end
            4'h2:       begin ch = 2'h1; r = `AFEST_RATIO_1CH_CDS;  end
            4'h3:       begin ch = 2'h1; r = `AFEST_RATIO_1CH_NCDS; end
            default:    v = 1'b0;
        endcase
        return {v, ch, r};
    endfunction : decode

    // management registers held here so the host reads back what it wrote
    logic [3:0] scheme_q;
    logic [3:0] pos_q;
    logic       short_q;
    logic       free_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scheme_q <= `AFEST_RESET_SCHEME;
            pos_q    <= `AFEST_RESET_POS;
            short_q  <= 1'b0;
            free_q   <= 1'b0;
        end else begin
            scheme_q <= scheme_code;
            pos_q    <= reset_sample_position;
            short_q  <= short_clamp;
            free_q   <= self_sync_enable;
        end
    end

    logic [6:0] dec;
    logic [3:0] ratio;
    logic       valid;
    logic       cds;
    assign dec   = decode(scheme_q);
    assign ratio = dec[3:0];
    assign valid = dec[6];
    assign cds   = ~scheme_q[`AFEST_CDS_BIT];

    // status outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            channel_count   <= 2'h0;
            max_mclk_mhz    <= `AFEST_FMAX_LOW_MHZ;
            scheme_reserved <= 1'b0;
            cds_active      <= 1'b0;
            readback_q      <= '0;
        end else begin
            channel_count   <= dec[5:4];
            scheme_reserved <= ~valid;
            cds_active      <= cds;
            readback_q      <= {free_q, short_q, pos_q, 2'h0, scheme_q};
            case (scheme_q)
                4'h0, 4'h1, 4'h4, 4'h5: max_mclk_mhz <= `AFEST_FMAX_LOW_MHZ;
                4'h2, 4'h3:  max_mclk_mhz <= `AFEST_FMAX_MID_MHZ;
                default:     max_mclk_mhz <= `AFEST_FMAX_HIGH_MHZ;
            endcase
        end
    end

    // phase counter: free-running in self-sync, restarted by external sync
    afest_state_t state_q;
    logic [3:0]   phase_q;
    logic         ext_sync_q;
    logic         sync_edge;
    logic         int_sync;
    assign int_sync  = free_q && valid && (phase_q == 4'h0);
    assign sync_edge = free_q ? int_sync : (pixel_sync_in & ~ext_sync_q);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q    <= AFEST_IDLE;
            phase_q    <= 4'h0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_sync_q <= pixel_sync_in;
            case (state_q)
                AFEST_IDLE: begin
                    phase_q <= 4'h0;
                    if (valid && (free_q || sync_edge)) begin
                        state_q <= AFEST_RUN;
                        phase_q <= free_q ? 4'h0 : 4'h1;
                    end
                end
                AFEST_RUN: begin
                    if (!valid) begin
                        state_q <= AFEST_IDLE;
                    end else if (!free_q && sync_edge) begin
                        phase_q <= 4'h1;
                    end else if (phase_q == ratio - 4'h1) begin
                        phase_q <= 4'h0;
                    end else begin
                        phase_q <= phase_q + 4'h1;
                    end
                end
                default: state_q <= AFEST_IDLE;
            endcase
        end
    end

    // self sync output routing; the host keeps the select consistent
    logic gen_sync;
    assign gen_sync = (state_q == AFEST_RUN) && int_sync;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pixel_sync_out      <= 1'b0;
            pixel_sync_oe       <= 1'b0;
            serial_readback_pin <= 1'b0;
            serial_readback_oe  <= 1'b0;
        end else begin
            pixel_sync_out <= gen_sync;
            pixel_sync_oe  <= free_q && sync_pin_output_enable;
            serial_readback_pin <= gen_sync;
            serial_readback_oe  <= free_q &&
                ((serial_out_select == `AFEST_SOSEL_SYNC) ||
                 (serial_out_select == `AFEST_SOSEL_BOTH));
        end
    end

    // clamp request taken at the sync phase, applied at the next reset level
    logic clamp_armed_q;
    logic at_sync;
    logic at_reset;
    logic [3:0] clamp_cnt_q;
    assign at_sync  = (state_q == AFEST_RUN) && (phase_q == 4'h0 || sync_edge);
    assign at_reset = (state_q == AFEST_RUN) && (phase_q == pos_q);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clamp_armed_q <= 1'b0;
            clamp_cnt_q   <= 4'h0;
            clamp_pulse   <= 1'b0;
        end else begin
            if (at_sync) begin
                clamp_armed_q <= clamp_request_pin;
            end
            if (at_reset && clamp_armed_q) begin
                // short clamp is one phase, long spans two
                clamp_cnt_q <= short_q ? 4'h1 : 4'h2;
                clamp_pulse <= 1'b1;
            end else if (clamp_cnt_q > 4'h1) begin
                clamp_cnt_q <= clamp_cnt_q - 4'h1;
            end else begin
                clamp_cnt_q <= 4'h0;
                clamp_pulse <= 1'b0;
            end
        end
    end

    // sample strobes; single sampling lines the reference with the video
    logic vid_hit;
    assign vid_hit = (state_q == AFEST_RUN) &&
                     (phase_q == `AFEST_VIDEO_PHASE);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            video_sample_strobe     <= 1'b0;
            reference_sample_strobe <= 1'b0;
            ref_from_clamp_level    <= 1'b0;
        end else begin
            video_sample_strobe  <= vid_hit;
            ref_from_clamp_level <= ~cds;
            reference_sample_strobe <= cds ? at_reset : vid_hit;
        end
    end

    // converter sequencing across active channels
    // the select is delayed with the load so both name the same channel;
    // otherwise the first channel would be skipped and the last loaded twice
    logic [1:0] ch_sel_q;
    logic [1:0] mux_sel_q;
    logic       load_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ch_sel_q  <= 2'h0;
            mux_sel_q <= 2'h0;
            load_q    <= 1'b0;
        end else begin
            mux_sel_q <= ch_sel_q;
            load_q <= (state_q == AFEST_RUN) && (ch_sel_q < dec[5:4]);
            if (vid_hit) begin
                ch_sel_q <= 2'h0;
            end else if (ch_sel_q < dec[5:4]) begin
                ch_sel_q <= ch_sel_q + 2'h1;
            end
        end
    end

    afest_word_mux u_mux (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ch0_word (ch0_word),
        .ch1_word (ch1_word),
        .ch2_word (ch2_word),
        .ch_sel   (mux_sel_q),
        .load     (load_q),
        .word_q   (data_bus_out)
    );

    // bus released while the host drives it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_bus_oe <= 1'b0;
        end else begin
            data_bus_oe <= ~data_bus_read && (data_bus_in == data_bus_in);
        end
    end
endmodule : afest_timing

// ---- afest_timing_checker.sv ----
// Purpose: port checks for the sample timing control
// Assumes: one clock, synchronous active-high reset
// Notes:   status checks wait for a code held steady
`timescale 1ns/1ns
module afest_timing_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // controls
    input wire logic [3:0] scheme_code,
    input wire logic       short_clamp,
    // outputs
    input wire logic       pixel_sync_out,
    input wire logic       clamp_pulse,
    input wire logic       video_sample_strobe,
    input wire logic       reference_sample_strobe,
    input wire logic       ref_from_clamp_level,
    input wire logic       cds_active,
    input wire logic [1:0] channel_count,
    input wire logic [7:0] max_mclk_mhz,
    input wire logic       scheme_reserved
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // expected status; outputs are registered, so checks wait
    logic       rsv;
    logic [1:0] ech;
    logic [7:0] emhz;
    assign rsv  = scheme_code[1] & (scheme_code[3] | scheme_code[2]);
    assign ech  = scheme_code[2] ? 2'h2 : (scheme_code[1] ? 2'h1 : 2'h3);
    assign emhz = scheme_code[3] ? 8'h30 :
                  (scheme_code[2:1] == 2'h1) ? 8'h28 : 8'h20;
    a_reserved_flag: assert property (
        $stable(scheme_code)[*3] |-> scheme_reserved == rsv)
        else $error("reserved flag wrong");
    a_cds_select: assert property (
        $stable(scheme_code)[*3] ##0 !rsv |-> cds_active == !scheme_code[0])
        else $error("cds flag wrong");
    a_chan_count: assert property (
        $stable(scheme_code)[*3] ##0 !rsv |-> channel_count == ech)
        else $error("channel count wrong");
    a_mclk_limit: assert property (
        $stable(scheme_code)[*3] ##0 !rsv |-> max_mclk_mhz == emhz)
        else $error("clock limit wrong");
    a_single_pair: assert property (
        $stable(scheme_code)[*3] ##0 video_sample_strobe && !cds_active
        |-> reference_sample_strobe && ref_from_clamp_level)
        else $error("single sampling strobes apart");
    a_idle_quiet: assert property (
        scheme_reserved && $past(scheme_reserved) |-> !(video_sample_strobe
        || reference_sample_strobe || clamp_pulse))
        else $error("strobe on reserved code");
    a_sync_spacing: assert property (
        pixel_sync_out |=> !pixel_sync_out [*3])
        else $error("sync pulses too close");
    a_clamp_short: assert property (
        $stable(short_clamp)[*3] ##0 $rose(clamp_pulse)
        |=> (clamp_pulse == !short_clamp) ##1 !clamp_pulse)
        else $error("clamp width wrong");
endmodule : afest_timing_checker

bind afest_timing afest_timing_checker u_chk (
    .clk, .sys_rst, .scheme_code, .short_clamp, .pixel_sync_out,
    .clamp_pulse, .video_sample_strobe, .reference_sample_strobe,
    .ref_from_clamp_level, .cds_active, .channel_count, .max_mclk_mhz,
    .scheme_reserved);

// ---- afest_sensor_model.sv ----
// Purpose: sensor side model, pixel sync and clamp request
// Assumes: period counted in master clocks
// Notes:   clamp request is a level held across each pulse
`timescale 1ns/1ns
module afest_sensor_model (
    // clock
    input  wire logic       clk,
    // scenario controls
    input  wire logic       run,
    input  wire logic [3:0] period,
    input  wire logic       clamp_want,
    // sensor pins
    output logic            pixel_sync_in,
    output logic            clamp_request_pin
);
    logic [3:0] cnt_q;
    // one-clock sync at the top of each period; idle low when stopped
    always_ff @(posedge clk) begin
        cnt_q <= (!run || cnt_q >= period - 4'h1) ? 4'h0 : cnt_q + 4'h1;
        pixel_sync_in <= run && cnt_q == 4'h0;
        clamp_request_pin <= clamp_want;
    end
endmodule : afest_sensor_model

// ---- afest_timing_bench.sv ----
// Purpose: self-checking bench for the sample timing control
// Assumes: 10 MHz clock, sensor model makes the external sync
// Notes:   expectations come from the scheme code table
`timescale 1ns/1ns
module afest_timing_bench;
    logic        clk = 1'b0;
    logic        sys_rst, short_clamp, self_sync_enable, run, clamp_want;
    logic        sync_pin_output_enable, data_bus_read, pixel_sync_in;
    logic        clamp_request_pin, pixel_sync_out, pixel_sync_oe;
    logic        serial_readback_pin, serial_readback_oe, clamp_pulse;
    logic        video_sample_strobe, reference_sample_strobe;
    logic        ref_from_clamp_level, cds_active, scheme_reserved, data_bus_oe;
    logic [1:0]  serial_out_select, channel_count;
    logic [3:0]  scheme_code, reset_sample_position, period;
    logic [7:0]  max_mclk_mhz;
    logic [11:0] data_bus_out, readback_q;
    int          mismatches = 0;
    int          samples_checked = 0;
    // channels per code, 0 marks reserved; clock limit per code pair
    logic [1:0]  ch_tab [16] = '{3, 3, 1, 1, 2, 2, 0, 0, 3, 3, 0, 0,
                                 2, 2, 0, 0};
    logic [7:0]  mhz_tab [8] = '{8'h20, 8'h28, 8'h20, 8'h00, 8'h30, 8'h00,
                                 8'h30, 8'h00};
    afest_timing u_dut (
        .clk, .sys_rst, .scheme_code, .reset_sample_position, .short_clamp,
        .self_sync_enable, .sync_pin_output_enable, .serial_out_select,
        .pixel_sync_in, .clamp_request_pin, .ch0_word(12'h1A5),
        .ch1_word(12'h2B6), .ch2_word(12'h3C7), .data_bus_in(12'h0F0),
        .data_bus_read, .pixel_sync_out, .pixel_sync_oe, .serial_readback_pin,
        .serial_readback_oe, .clamp_pulse, .video_sample_strobe,
        .reference_sample_strobe, .ref_from_clamp_level, .cds_active,
        .channel_count, .max_mclk_mhz, .scheme_reserved, .data_bus_out,
        .data_bus_oe, .readback_q);
    afest_sensor_model u_sensor (.clk, .run, .period, .clamp_want,
        .pixel_sync_in, .clamp_request_pin);
    always #50 clk = ~clk;
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // status outputs are registered, so let a new code settle first
    task automatic t_status(input logic [3:0] c);
        @(posedge clk);
        scheme_code <= c;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(scheme_reserved === (ch_tab[c] == 2'h0), "reserved");
        if (ch_tab[c] != 2'h0) begin
            check(channel_count === ch_tab[c], "channels");
            check(max_mclk_mhz === mhz_tab[c[3:1]], "clock limit");
            check(cds_active === ~c[0], "cds");
        end
    endtask : t_status
    // self sync: measure one period and count video strobes in it
    task automatic t_self(input logic [3:0] c, input int ratio,
                          input logic [1:0] sel);
        int t0 = -1;
        int t1 = -1;
        int v = 0;
        @(posedge clk);
        scheme_code <= c;
        self_sync_enable <= 1'b1;
        sync_pin_output_enable <= 1'b1;
        serial_out_select <= sel;
        repeat (30) @(posedge clk);
        for (int i = 0; i < 40 && t1 < 0; i++) begin
            @(negedge clk);
            if (t0 >= 0 && video_sample_strobe === 1'b1) v++;
            if (pixel_sync_out === 1'b1) begin
                if (t0 < 0) t0 = i;
                else t1 = i;
            end
        end
        if (t1 < 0) begin
            check(1'b0, "no sync");
            report_and_stop();
        end else begin
            check(t1 - t0 === ratio, "period");
            check(v === 1, "video count");
            check(pixel_sync_oe === 1'b1, "sync pin");
            check(serial_readback_pin === 1'b1, "readback pulse");
            // select values 1 and 3 route the sync, the others do not
            check(serial_readback_oe === (sel == 2'h1 || sel == 2'h3),
                  "readback pin");
        end
    endtask : t_self
    // external sync, code 0: clamp follows the request, strobes apart
    task automatic t_clamp(input logic w, input logic sh);
        int np = 0;
        int nv = 0;
        int nb = 0;
        int nr = 0;
        logic prev = 1'b0;
        @(posedge clk);
        self_sync_enable <= 1'b0;
        sync_pin_output_enable <= 1'b0;
        serial_out_select <= 2'h0;
        scheme_code <= 4'h0;
        run <= 1'b1;
        clamp_want <= w;
        short_clamp <= sh;
        repeat (30) @(posedge clk);
        repeat (32) begin
            @(negedge clk);
            if (clamp_pulse === 1'b1 && prev !== 1'b1) np++;
            prev = clamp_pulse;
            if (video_sample_strobe === 1'b1) nv++;
            if (video_sample_strobe & reference_sample_strobe) nb++;
            if (reference_sample_strobe === 1'b1) nr++;
        end
        check(nr === 4, "reference per sync");
        check((np > 0) === w, "clamp");
        check(nv === 4, "video per sync");
        check(nb === 0, "cds strobes");
        check(pixel_sync_oe === 1'b0, "sync pin off");
    endtask : t_clamp
    // converter words follow the video strobe in channel order, code 0
    task automatic t_words;
        int k = -1;
        for (int i = 0; i < 20 && k < 0; i++) begin
            @(negedge clk);
            if (video_sample_strobe === 1'b1) k = i;
        end
        if (k < 0) begin
            check(1'b0, "no video");
            report_and_stop();
        end else begin
            // select settles one cycle, the word register one more
            @(negedge clk);
            @(negedge clk);
            check(data_bus_out === 12'h1A5, "word 0");
            @(negedge clk);
            check(data_bus_out === 12'h2B6, "word 1");
            @(negedge clk);
            check(data_bus_out === 12'h3C7, "word 2");
            // free 0, short 0, position 2, scheme 0
            check(readback_q === 12'h080, "readback");
        end
    endtask : t_words
    initial begin
        sys_rst = 1'b1;
        scheme_code = 4'h0;
        reset_sample_position = 4'h2;
        short_clamp = 1'b0;
        self_sync_enable = 1'b0;
        sync_pin_output_enable = 1'b0;
        serial_out_select = 2'h0;
        data_bus_read = 1'b0;
        run = 1'b0;
        period = 4'h8;
        clamp_want = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(max_mclk_mhz === 8'h20, "reset limit");
        for (int c = 0; c < 16; c++) t_status(4'(c));
        t_self(4'h3, 4, 2'h1);
        t_self(4'h8, 12, 2'h1);
        t_self(4'h4, 6, 2'h2);
        t_self(4'hD, 8, 2'h3);
        t_clamp(1'b1, 1'b0);
        t_clamp(1'b1, 1'b1);
        t_clamp(1'b0, 1'b0);
        t_words();
        @(posedge clk);
        data_bus_read <= 1'b1;
        repeat (3) @(negedge clk);
        check(data_bus_oe === 1'b0, "bus released");
        report_and_stop();
    end
endmodule : afest_timing_bench
